// [bench/spio_link_checker.sv]
// Concurrent checks on the signals between the two port ends
`timescale 1ns/1ns
module spio_link_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        accessReq,
  input wire logic        storeOp,
  input wire logic        doubleCycle,
  input wire logic        testAndSet,
  input wire logic        operationValid,
  input wire logic        suppressLogCheck,
  input wire logic        ignoreErrors,
  input wire logic        powerGood,
  input wire logic [4:0]  byteMark,
  input wire logic [35:0] outBus,
  input wire logic        accept,
  input wire logic        reqAck,
  input wire logic        gateData,
  input wire logic        storageCheck,
  input wire logic        storageHalted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_accept_pulse: assert property (accept |=> !accept)
    else $error("accept held too long");
  a_accept_cause: assert property (accept |-> $past(accessReq) && $past(powerGood))
    else $error("accept without powered request");
  a_ack_cause: assert property (reqAck |-> powerGood && accessReq)
    else $error("acknowledge without request");
  a_req_hold: assert property (accessReq && !accept && !storageCheck |=> accessReq)
    else $error("request dropped before accept");
  a_addr_format: assert property (accessReq |->
    outBus[27:24] == 4'h0 && ^{outBus[35], outBus[31:24]})
    else $error("bad address phase byte");
  a_marks_store: assert property (byteMark != 5'h0 |->
    $past(accept) && $past(storeOp) && ^byteMark)
    else $error("marks outside store data phase");
  a_gate_fetch: assert property (gateData |-> $past(accept, 2) && !$past(storeOp, 2))
    else $error("gate data without fetch");
  a_check_cause: assert property (storageCheck |-> $past(accessReq))
    else $error("check without request");
  a_halt_quiet: assert property (storageHalted && $past(storageHalted) |->
    !accept && !gateData)
    else $error("activity while halted");
  a_op_valid: assert property (accessReq && !ignoreErrors |->
    operationValid == !(testAndSet || suppressLogCheck || doubleCycle))
    else $error("operation valid line wrong");
endmodule : spio_link_checker

// [bench/tb_top.sv]
// Bench joining both port ends, compared with a word-level storage model
`timescale 1ns/1ns
module tb_top;
  import spio_pkg::*;
  localparam logic [3:0] TAG = 4'h5;
  logic        clk, rst, powerOk, reqValid, reqStore, reqDouble, reqTas, reqSuppress;
  logic        reqBaseArea, multiAccept, logoutDone, logoutClear, reqReady, rspValid;
  logic        rspCheck, seHalted, logoutActive, elementCheckPulse, lockOthers, waitExpired;
  logic [3:0]  reqKey, reqMarks;
  logic [23:0] reqAddr, a;
  logic [31:0] reqData, rspData, d;
  logic [31:0] mem [int];
  int          n_mismatch, cmp_count, nRsp, nElc, g, e0;

  spio_if lnk ();
  spio_storage_end spio_storage_end_i (
    .clk(clk), .rst(rst), .tagStrap(TAG), .tagStrapPar(~^TAG), .configured(1'b1),
    .multiAccept(multiAccept), .logoutDone(logoutDone), .elementCheckPulse(elementCheckPulse),
    .lockOthers(lockOthers), .waitExpired(waitExpired), .sp(lnk)
  );
  spio_requester_end spio_requester_end_i (
    .clk(clk), .rst(rst), .powerOk(powerOk), .reqValid(reqValid), .reqReady(reqReady),
    .reqStore(reqStore), .reqDouble(reqDouble), .reqTas(reqTas), .reqSuppress(reqSuppress),
    .reqIgnore(1'b0), .reqBaseArea(reqBaseArea), .reqKey(reqKey), .reqAddr(reqAddr),
    .reqData(reqData), .reqMarks(reqMarks), .rspValid(rspValid), .rspData(rspData),
    .rspCheck(rspCheck), .seHalted(seHalted), .logoutClear(logoutClear),
    .logoutActive(logoutActive), .sp(lnk)
  );
  spio_link_checker chk_i (
    .clk(clk), .rst(rst), .accessReq(lnk.accessReq), .storeOp(lnk.storeOp),
    .doubleCycle(lnk.doubleCycle), .testAndSet(lnk.testAndSet),
    .operationValid(lnk.operationValid), .suppressLogCheck(lnk.suppressLogCheck),
    .ignoreErrors(lnk.ignoreErrors), .powerGood(lnk.powerGood), .byteMark(lnk.byteMark),
    .outBus(lnk.outBus), .accept(lnk.accept), .reqAck(lnk.reqAck), .gateData(lnk.gateData),
    .storageCheck(lnk.storageCheck), .storageHalted(lnk.storageHalted)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Sampled mid-cycle so register updates at the edge never race the count
  always @(negedge clk) begin
    if (rspValid === 1'b1) nRsp++;
    if (elementCheckPulse === 1'b1) nElc++;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  function automatic logic [23:0] adr(input int idx, input int lo);
    return {1'b0, TAG, 10'h0, 6'(idx), 3'(lo)};
  endfunction : adr

  // One request through the user handshake; g is 1 on data, 2 on check
  task automatic op(input logic st, input logic tas, input logic dbl,
                    input logic [23:0] ad, input logic [31:0] dt);
    int i;
    @(posedge clk);
    {reqValid, reqStore, reqTas, reqDouble, reqAddr, reqData} <= {1'b1, st, tas, dbl, ad, dt};
    {reqKey, reqSuppress, reqBaseArea} <= 6'($urandom);
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (reqReady !== 1'b1 && i < 300);
    if (reqReady !== 1'b1) begin
      n_mismatch++;
      results();
    end
    @(posedge clk);
    reqValid <= 1'b0;
    g = 0;
    for (i = 0; i < 150 && g == 0; i++) begin
      @(negedge clk);
      if (rspValid === 1'b1) g = 1;
      if (rspCheck === 1'b1) g = 2;
    end
  endtask : op

  task automatic rd(input logic [23:0] ad);
    op(1'b0, 1'b0, 1'b0, ad, 32'h0);
    chk(g, 1);
    chk(rspData, mem[ad[8:2]]);
  endtask : rd

  task automatic wr(input logic [23:0] ad, input logic dbl);
    d = $urandom;
    op(1'b1, 1'b0, dbl, ad, d);
    mem[ad[8:2]] = d;
  endtask : wr

  task automatic waitHalt(input logic v);
    int i;
    for (i = 0; i < 200 && seHalted !== v; i++) @(negedge clk);
    chk(seHalted, v);
    if (seHalted !== v) results();
  endtask : waitHalt

  initial begin
    rst = 1'b1;
    {powerOk, reqValid, reqStore, reqDouble, reqTas, reqSuppress, reqBaseArea} = '0;
    {multiAccept, logoutDone, logoutClear, reqKey, reqAddr, reqData} = '0;
    reqMarks = 4'hf;
    void'($urandom(32'hb01c));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    powerOk <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      a = adr($urandom_range(7), $urandom_range(7));
      if (mem.exists(a[8:2]) && $urandom_range(1)) rd(a);
      else wr(a, 1'b0);
    end
    // byte lock at every byte of a doubleword
    for (int b = 0; b < 8; b++) begin
      a = adr(20, b);
      wr(adr(20, 0), 1'b0);
      wr(adr(20, 4), 1'b0);
      op(1'b0, 1'b1, 1'b0, a, 32'h0);
      chk(rspData, mem[a[8:2]]);
      mem[a[8:2]][31 - 8 * int'(a[1:0]) -: 8] = 8'hff;
      rd(adr(20, 0));
      rd(adr(20, 4));
    end
    // a request waits while power good is low
    wr(adr(3, 0), 1'b0);
    powerOk <= 1'b0;
    e0 = nRsp;
    fork
      rd(adr(3, 0));
    join_none
    repeat (40) @(posedge clk);
    chk(nRsp, e0);
    powerOk <= 1'b1;
    wait fork;
    // tag mismatch, then multiple accept; each ends in a logout halt
    for (int k = 0; k < 2; k++) begin
      e0 = nElc;
      multiAccept <= k[0];
      a = adr(5, 0);
      a[22:19] = k ? TAG : ~TAG;
      op(1'b0, 1'b0, 1'b0, a, 32'h0);
      multiAccept <= 1'b0;
      chk(g, 2);
      chk(nElc, e0 + 1);
      waitHalt(1'b1);
      // Drop the stop request first, else the pending latch re-arms on release
      @(posedge clk);
      logoutClear <= 1'b1;
      @(posedge clk);
      {logoutDone, logoutClear} <= 2'h2;
      @(posedge clk);
      logoutDone <= 1'b0;
      waitHalt(1'b0);
    end
    // paired cycles, then a second request that never comes
    wr(adr(9, 0), 1'b1);
    wr(adr(9, 0), 1'b0);
    rd(adr(9, 0));
    e0 = nElc;
    wr(adr(9, 4), 1'b1);
    repeat (DBL_TIMEOUT_CYC + 40) @(posedge clk);
    chk(nElc, e0 + 1);
    rd(adr(9, 0));
    results();
  end
endmodule : tb_top

// [rtl/spio_if.sv]
// Point-to-point link between requester and storage element
`timescale 1ns/1ns
interface spio_if;
  logic        accessReq;
  logic        storeOp;
  logic        doubleCycle;
  logic        testAndSet;
  logic        operationValid;
  logic        suppressLogCheck;
  logic        ignoreErrors;
  logic        logoutHaltRequest;
  logic        powerGood;
  logic [4:0]  byteMark;
  logic [35:0] outBus;
  logic        accept;
  logic        reqAck;
  logic        gateData;
  logic        storageCheck;
  logic        storageHalted;
  logic [35:0] inBus;

  modport storage_element (
    input  accessReq, storeOp, doubleCycle, testAndSet, operationValid,
    input  suppressLogCheck, ignoreErrors, logoutHaltRequest, powerGood,
    input  byteMark, outBus,
    output accept, reqAck, gateData, storageCheck, storageHalted, inBus
  );
  modport io_control_element (
    output accessReq, storeOp, doubleCycle, testAndSet, operationValid,
    output suppressLogCheck, ignoreErrors, logoutHaltRequest, powerGood,
    output byteMark, outBus,
    input  accept, reqAck, gateData, storageCheck, storageHalted, inBus
  );
endinterface : spio_if

// [rtl/spio_pkg.sv]
// Shared constants, types and parity helpers for the storage port
package spio_pkg;
  localparam int BUS_W           = 36;
  localparam int DATA_W          = 32;
  localparam int MARK_W          = 5;
  localparam int KEY_MSB         = 31;
  localparam int KEY_LSB         = 28;
  localparam int TAG_MSB         = 22;
  localparam int TAG_LSB         = 19;
  localparam int BSEL_MSB        = 2;
  localparam int WSEL_BIT        = 2;
  localparam int IDX_MSB         = 8;
  localparam int IDX_LSB         = 3;
  localparam int IDX_W           = IDX_MSB - IDX_LSB + 1;
  localparam int MEM_DEPTH       = 64;
  localparam int FIFO_DEPTH      = 16;
  localparam int FIFO_W          = IDX_W + 1 + 4 + DATA_W;
  localparam int CLK_NS          = 4;
  localparam int DBL_TIMEOUT_NS  = 2000;
  localparam int DBL_TIMEOUT_CYC = DBL_TIMEOUT_NS / CLK_NS;
  localparam int WAIT_TIMEOUT_NS = 4000;
  localparam int WAIT_CYC        = WAIT_TIMEOUT_NS / CLK_NS;
  localparam int CNT_W           = 12;

  typedef enum logic [4:0] {
    SE_IDLE  = 5'b0_0001,
    SE_ACC   = 5'b0_0010,
    SE_STORE = 5'b0_0100,
    SE_FETCH = 5'b0_1000,
    SE_HALT  = 5'b1_0000
  } spio_se_state_t;

  typedef enum logic [3:0] {
    RQ_IDLE = 4'b0001,
    RQ_REQ  = 4'b0010,
    RQ_DATA = 4'b0100,
    RQ_WAIT = 4'b1000
  } spio_rq_state_t;

  // Byte 0 is the most significant byte; its parity sits at bit 35
  function automatic logic [3:0] spio_gen_par(input logic [31:0] w);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 4; i++) begin
      p[3-i] = ~^w[31-8*i -: 8];
    end
    return p;
  endfunction : spio_gen_par

  function automatic logic spio_bus_ok(input logic [35:0] b);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ok = ok & (^{b[31-8*i -: 8], b[35-i]});
    end
    return ok;
  endfunction : spio_bus_ok
endpackage : spio_pkg

// [rtl/spio_requester_end.sv]
// I/O control element end of the storage port
`timescale 1ns/1ns
module spio_requester_end
  import spio_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        powerOk,
  input  wire logic        reqValid,
  output      logic        reqReady,
  input  wire logic        reqStore,
  input  wire logic        reqDouble,
  input  wire logic        reqTas,
  input  wire logic        reqSuppress,
  input  wire logic        reqIgnore,
  input  wire logic        reqBaseArea,
  input  wire logic [3:0]  reqKey,
  input  wire logic [23:0] reqAddr,
  input  wire logic [31:0] reqData,
  input  wire logic [3:0]  reqMarks,
  output      logic        rspValid,
  output      logic [31:0] rspData,
  output      logic        rspCheck,
  output      logic        seHalted,
  input  wire logic        logoutClear,
  output      logic        logoutActive,
  spio_if.io_control_element sp
);
  spio_rq_state_t state_q;
  logic [35:0] bus_q;
  logic [4:0]  marks_q;
  logic [31:0] data_q;
  logic [3:0]  markSel_q;
  logic        store_q;
  logic        dbl_q;
  logic        tas_q;
  logic        slc_q;
  logic        ign_q;
  logic        rspValid_q;
  logic [31:0] rspData_q;
  logic        rspCheck_q;
  logic        halted_q;
  logic        los_q;
  logic        take;
  logic [31:0] addrWord;

  assign reqReady = (state_q == RQ_IDLE) & ~los_q & ~halted_q & powerOk;
  assign take     = reqValid & reqReady;
  // R2 key in bits 0-3, bits 4-7 zero; R3 base area forces key to zero
  assign addrWord = {(reqBaseArea ? 4'h0 : reqKey), 4'h0, reqAddr};

  // R10 request held from the first cycle until accept
  assign sp.accessReq      = (state_q == RQ_REQ);
  // R11 store line rides only with the request
  assign sp.storeOp        = (state_q == RQ_REQ) & store_q;
  assign sp.doubleCycle    = (state_q == RQ_REQ) & dbl_q;
  assign sp.testAndSet     = (state_q == RQ_REQ) & tas_q;
  assign sp.suppressLogCheck = (state_q == RQ_REQ) & slc_q;
  assign sp.ignoreErrors   = (state_q == RQ_REQ) & ign_q;
  // R6 operation-valid only with a plain fetch or store
  assign sp.operationValid = (state_q == RQ_REQ) & ~(dbl_q | tas_q | slc_q);
  assign sp.logoutHaltRequest = los_q;
  assign sp.powerGood      = powerOk;
  assign sp.outBus         = bus_q;
  assign sp.byteMark       = marks_q;
  assign rspValid = rspValid_q;
  assign rspData  = rspData_q;
  assign rspCheck = rspCheck_q;
  assign seHalted = halted_q;
  assign logoutActive = los_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RQ_IDLE;
    end else begin
      unique case (state_q)
        RQ_IDLE: begin
          if (take) begin
            state_q <= RQ_REQ;
          end
        end
        RQ_REQ: begin
          if (sp.accept) begin
            state_q <= store_q ? RQ_DATA : RQ_WAIT;
          end else if (sp.storageCheck) begin
            state_q <= RQ_IDLE;
          end
        end
        RQ_DATA: begin
          state_q <= RQ_IDLE;
        end
        RQ_WAIT: begin
          if (sp.gateData) begin
            state_q <= RQ_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_q     <= 36'h0_0000_0000;
      marks_q   <= 5'h00;
      data_q    <= 32'h0000_0000;
      markSel_q <= 4'h0;
      store_q   <= 1'b0;
      dbl_q     <= 1'b0;
      tas_q     <= 1'b0;
      slc_q     <= 1'b0;
      ign_q     <= 1'b0;
    end else if (take) begin
      // R1 address and key go out first on the shared bus
      // R3 base-area key parity forced to one
      bus_q     <= {(reqBaseArea ? 1'b1 : spio_gen_par(addrWord)[3]),
                    spio_gen_par(addrWord)[2:0], addrWord};
      data_q    <= reqData;
      markSel_q <= reqMarks;
      store_q   <= reqStore;
      dbl_q     <= reqDouble;
      tas_q     <= reqTas & ~reqStore;
      slc_q     <= reqSuppress;
      ign_q     <= reqIgnore;
    end else if ((state_q == RQ_REQ) & sp.accept & store_q) begin
      // R1 store data replaces the address after accept
      // R9 marks driven only for stores, odd parity
      bus_q   <= {spio_gen_par(data_q), data_q};
      marks_q <= {markSel_q, ~^markSel_q};
    end else if (state_q == RQ_DATA) begin
      // R22 data and marks stood through the storage cycle
      marks_q <= 5'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rspValid_q <= 1'b0;
      rspData_q  <= 32'h0000_0000;
      rspCheck_q <= 1'b0;
      halted_q   <= 1'b0;
    end else begin
      rspValid_q <= (state_q == RQ_WAIT) & sp.gateData;
      rspCheck_q <= sp.storageCheck;
      halted_q   <= sp.storageHalted;
      if ((state_q == RQ_WAIT) & sp.gateData) begin
        rspData_q <= sp.inBus[31:0];
      end
    end
  end

  // R12 logout stop after storage check or fetch data check; set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      los_q <= 1'b0;
    end else if (sp.storageCheck |
                 ((state_q == RQ_WAIT) & sp.gateData & ~spio_bus_ok(sp.inBus))) begin
      los_q <= 1'b1;
    end else if (logoutClear) begin
      los_q <= 1'b0;
    end
  end
endmodule : spio_requester_end

// [rtl/spio_storage_end.sv]
// Storage element end of the port with its store-write FIFO
`timescale 1ns/1ns
module spio_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         inValid,
  output      logic         inReady,
  input  wire logic [W-1:0] inData,
  output      logic         outValid,
  input  wire logic         outReady,
  output      logic [W-1:0] outData
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign inReady  = (cnt_q != (AW+1)'(D));
  assign outValid = (cnt_q != '0);
  assign outData  = mem[rd_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q  <= pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end
endmodule : spio_fifo

// Operation
// R1 - Shared bus: address+key first, data after accept
// R2 - Requester keeps key bits 0-3, zeros 4-7
// R3 - Base-area access: key zero, key parity one
// R4 - Box tag bits 1-4 checked against strap
// R5 - Test-and-set returns byte, then writes ones
// R6 - Operation-valid mismatch halts element, check, pulse
// R7 - Double cycle; late second request times out
// R8 - Power-good interlock gates request latches
// R9 - Byte marks with odd parity, stores only
// R10 - Request held from cycle start until accept
// R11 - Store line dropped before next scan
// R12 - Logout stop halts element after current cycle
// R13 - Suppress-log-check hides data error reports
// R14 - Ignore-errors affects only operation check
// R15 - Fetch returns 32 data, 4 parity bits
// R16 - Accept takes request, calls for store data
// R17 - Acknowledge when request seen and configured
// R18 - Gate-data marks valid fetched word
// R19 - Storage check on parity, tag, op, multiaccept
// R20 - Every check pulses element check, starts wait
// R21 - Halted indication; all operations refused
// R22 - Store data and marks held to cycle end
module spio_storage_end
  import spio_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] tagStrap,
  input  wire logic       tagStrapPar,
  input  wire logic       configured,
  input  wire logic       multiAccept,
  input  wire logic       logoutDone,
  output      logic       elementCheckPulse,
  output      logic       lockOthers,
  output      logic       waitExpired,
  spio_if.storage_element sp
);
  spio_se_state_t state_q;
  logic [63:0]    mem [MEM_DEPTH];
  logic [35:0]    addr_q;
  logic           store_q;
  logic           tas_q;
  logic           slc_q;
  logic           dbl_q;
  logic [63:0]    rdDw_q;
  logic [35:0]    inBus_q;
  logic           gate_q;
  logic           check_q;
  logic           elc_q;
  logic           haltPend_q;
  logic           dblPend_q;
  logic [CNT_W-1:0] dblCnt_q;
  logic           waitAct_q;
  logic [CNT_W-1:0] waitCnt_q;
  logic           waitExp_q;
  logic           reqSeen;
  logic           take;
  logic           opBad;
  logic           addrBad;
  logic           markBad;
  logic           dataBad;
  logic           checkEv;
  logic           dblExpire;
  logic           qInValid;
  logic           qInReady;
  logic           qOutValid;
  logic           qOutReady;
  logic [FIFO_W-1:0] qOut;
  logic [31:0]    rdWord;

  // R8 receivers degated while the requester's power is not good
  assign reqSeen = sp.powerGood & sp.accessReq;
  // R17 acknowledge a recognised request on a configured port
  assign sp.reqAck = reqSeen & configured;
  // R16 accept for one cycle; stores then drive data next cycle
  assign sp.accept        = (state_q == SE_ACC);
  // R21 halted indication while stopped for logout
  assign sp.storageHalted = (state_q == SE_HALT);
  assign sp.gateData      = gate_q;
  assign sp.storageCheck  = check_q;
  assign sp.inBus         = inBus_q;
  assign elementCheckPulse = elc_q;
  // R12 keep higher-priority elements out while logout is pending
  assign lockOthers  = haltPend_q | (state_q == SE_HALT);
  assign waitExpired = waitExp_q;

  // R10 fetches wait for queued stores so reads see them
  assign take = (state_q == SE_IDLE) & reqSeen & configured & ~haltPend_q &
                (sp.storeOp ? qInReady : ~qOutValid);
  // R6 special operations must come without operation-valid
  // R14 ignore-errors only masks this operation check
  assign opBad = ~sp.ignoreErrors &
                 ((sp.testAndSet | sp.suppressLogCheck | sp.doubleCycle) ?
                  sp.operationValid : ~sp.operationValid);
  // R4 box tag compare and strap parity check
  assign addrBad = ~spio_bus_ok(sp.outBus) | ~(^{tagStrap, tagStrapPar}) |
                   (sp.outBus[TAG_MSB:TAG_LSB] != tagStrap) | multiAccept;
  // R9 marks carry odd parity over four selects
  assign markBad = (state_q == SE_STORE) & ~(^sp.byteMark);
  // R13 data errors are not reported under suppress-log-check
  assign dataBad = (state_q == SE_STORE) & ~spio_bus_ok(sp.outBus) & ~slc_q;
  // R19 all storage check causes gathered
  assign checkEv = (take & (opBad | addrBad)) | markBad | dataBad;
  assign dblExpire = dblPend_q & (dblCnt_q == CNT_W'(DBL_TIMEOUT_CYC - 1));

  assign rdWord = addr_q[WSEL_BIT] ? rdDw_q[31:0] : rdDw_q[63:32];

  // R1 store data is taken off the shared bus in the cycle after accept
  assign qInValid  = (state_q == SE_STORE) & ~markBad & ~dataBad;
  assign qOutReady = (state_q != SE_FETCH);

  spio_fifo #(
    .W (FIFO_W),
    .D (FIFO_DEPTH)
  ) u_wq (
    .clk      (clk),
    .rst      (rst),
    .inValid  (qInValid),
    .inReady  (qInReady),
    .inData   ({addr_q[IDX_MSB:IDX_LSB], addr_q[WSEL_BIT], sp.byteMark[4:1],
                sp.outBus[31:0]}),
    .outValid (qOutValid),
    .outReady (qOutReady),
    .outData  (qOut)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SE_IDLE;
    end else begin
      unique case (state_q)
        SE_IDLE: begin
          if (haltPend_q) begin
            state_q <= SE_HALT;
          end else if (take & opBad) begin
            // R6 the whole element stops on an invalid operation
            state_q <= SE_HALT;
          end else if (take & ~addrBad) begin
            state_q <= SE_ACC;
          end
        end
        SE_ACC: begin
          state_q <= store_q ? SE_STORE : SE_FETCH;
        end
        SE_STORE, SE_FETCH: begin
          // R12 stop only once the current cycle is complete
          state_q <= haltPend_q ? SE_HALT : SE_IDLE;
        end
        SE_HALT: begin
          if (logoutDone) begin
            state_q <= SE_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q  <= 36'h0_0000_0000;
      store_q <= 1'b0;
      tas_q   <= 1'b0;
      slc_q   <= 1'b0;
      dbl_q   <= 1'b0;
    end else if (take) begin
      addr_q  <= sp.outBus;
      store_q <= sp.storeOp;
      tas_q   <= sp.testAndSet;
      slc_q   <= sp.suppressLogCheck;
      dbl_q   <= sp.doubleCycle;
    end
  end

  always_ff @(posedge clk) begin
    if (state_q == SE_ACC) begin
      rdDw_q <= mem[addr_q[IDX_MSB:IDX_LSB]];
    end
  end

  // Queue drain and test-and-set never overlap: fetches start on empty
  always_ff @(posedge clk) begin
    if (qOutValid & qOutReady) begin
      for (int b = 0; b < 4; b++) begin
        if (qOut[DATA_W+3-b]) begin
          mem[qOut[FIFO_W-1 -: IDX_W]][(qOut[DATA_W+4] ? 31 : 63) - 8*b -: 8]
            <= qOut[31-8*b -: 8];
        end
      end
    end else if ((state_q == SE_FETCH) & tas_q) begin
      // R5 selected byte of the doubleword is regenerated as ones
      mem[addr_q[IDX_MSB:IDX_LSB]][63 - 8*addr_q[BSEL_MSB:0] -: 8] <= 8'hFF;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      inBus_q <= 36'h0_0000_0000;
      gate_q  <= 1'b0;
    end else begin
      gate_q <= (state_q == SE_FETCH);
      if (state_q == SE_FETCH) begin
        // R15 one word with byte parity per fetch
        // R18 gate-data rises with the word
        inBus_q <= {spio_gen_par(rdWord), rdWord};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      check_q <= 1'b0;
      elc_q   <= 1'b0;
    end else begin
      check_q <= checkEv;
      // R20 every check also pulses element check
      elc_q   <= checkEv | dblExpire;
    end
  end

  // R12 logout stop latches; set wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      haltPend_q <= 1'b0;
    end else if (sp.powerGood & sp.logoutHaltRequest) begin
      haltPend_q <= 1'b1;
    end else if ((state_q == SE_HALT) & logoutDone) begin
      haltPend_q <= 1'b0;
    end
  end

  // R7 second half of a double cycle must arrive within the timeout
  always_ff @(posedge clk) begin
    if (rst) begin
      dblPend_q <= 1'b0;
      dblCnt_q  <= '0;
    end else if (((state_q == SE_STORE) | (state_q == SE_FETCH)) & dbl_q) begin
      dblPend_q <= 1'b1;
      dblCnt_q  <= '0;
    end else if (take | dblExpire) begin
      dblPend_q <= 1'b0;
    end else if (dblPend_q) begin
      dblCnt_q <= CNT_W'(dblCnt_q + 1'b1);
    end
  end

  // R20 wait timeout for logout stop, started by any check
  always_ff @(posedge clk) begin
    if (rst) begin
      waitAct_q <= 1'b0;
      waitCnt_q <= '0;
      waitExp_q <= 1'b0;
    end else begin
      waitExp_q <= 1'b0;
      if (checkEv) begin
        waitAct_q <= 1'b1;
        waitCnt_q <= '0;
      end else if (waitAct_q & haltPend_q) begin
        waitAct_q <= 1'b0;
      end else if (waitAct_q) begin
        waitCnt_q <= CNT_W'(waitCnt_q + 1'b1);
        if (waitCnt_q == CNT_W'(WAIT_CYC - 1)) begin
          waitAct_q <= 1'b0;
          waitExp_q <= 1'b1;
        end
      end
    end
  end
endmodule : spio_storage_end
